/* File: srg_reset_generator.sv */
// supervisor reset generator: reset output with supply and manual timeout
//
// Operation
// RULE1: reset output asserted whenever supply-good indication is false.
// RULE2: supply good and manual released: reset holds one full timeout.
// RULE3: manual request low asserts reset; held while low plus one timeout.
// RULE4: select low picks short timeout option, select high picks long option.
// RULE5: active-high variant drives output high under the same conditions.
// RULE6: without manual input, assertion and timeout depend on supply only.
// RULE7: unconnected manual request counts as inactive high, as if pulled up.
// RULE8: counter restarts on any assertion; reset asserted out of power-up.

`include "srg_regs.svh"

module srg_reset_generator #(
  // variant options
  parameter bit ACTIVE_HIGH    = 1'h0,
  parameter bit HAS_MANUAL     = 1'h1,
  parameter bit HAS_SELECT     = 1'h1,
  parameter bit FIXED_SELECT   = 1'h1,
  // timeout lengths in milliseconds and in clock cycles
  parameter int SHORT_TIMEOUT_MS = `SRG_SHORT_TIMEOUT_MS,
  parameter int LONG_TIMEOUT_MS  = `SRG_LONG_TIMEOUT_MS,
  parameter int SHORT_TIMEOUT_CYCLES =
                  SHORT_TIMEOUT_MS * `SRG_CYCLES_PER_MS,
  parameter int LONG_TIMEOUT_CYCLES  =
                  LONG_TIMEOUT_MS * `SRG_CYCLES_PER_MS,
  parameter int CNT_W          = `SRG_CNT_W
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // monitored conditions, asynchronous pins
  input  wire logic supply_good,
  input  wire logic manual_reset_request_b,
  input  wire logic timeout_select,
  // reset toward the system
  output logic      reset_out,
  // status, polarity free
  output logic      reset_asserted,
  output logic      timeout_running
);

  // refuse settings the counter cannot serve
  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("counter width out of range");
    end
    if (SHORT_TIMEOUT_CYCLES < 1 || LONG_TIMEOUT_CYCLES < 1) begin : g_bad_lo
      $error("timeout must last at least one cycle");
    end
    if (longint'(SHORT_TIMEOUT_CYCLES) > (longint'(1) << CNT_W) - 1 ||
        longint'(LONG_TIMEOUT_CYCLES) > (longint'(1) << CNT_W) - 1)
    begin : g_bad_hi
      $error("timeout does not fit the counter");
    end
  endgenerate

  localparam logic [CNT_W-1:0] SHORT_LAST =
                               CNT_W'(SHORT_TIMEOUT_CYCLES - `SRG_CNT_STEP);
  localparam logic [CNT_W-1:0] LONG_LAST  =
                               CNT_W'(LONG_TIMEOUT_CYCLES - `SRG_CNT_STEP);
  localparam logic [CNT_W-1:0] CNT_START  = CNT_W'(`SRG_CNT_START);
  localparam logic [CNT_W-1:0] CNT_STEP   = CNT_W'(`SRG_CNT_STEP);
  localparam logic             OUT_ON     =
                               ACTIVE_HIGH ? `SRG_LVL_HIGH : `SRG_LVL_LOW;
  localparam logic             OUT_OFF    = ~OUT_ON;

  logic [`SRG_PIN_W-1:0] pin_raw;
  logic [`SRG_PIN_W-1:0] pin_sync;
  logic                  supply_good_s;
  logic                  manual_b_s;
  logic                  select_s;
  logic                  supply_fault;
  logic                  manual_active;
  logic                  cond_active;
  logic                  select_long;
  logic [CNT_W-1:0]      sel_last;
  logic [CNT_W-1:0]      last_q;
  logic [CNT_W-1:0]      last_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic                  cnt_done;
  logic                  asserted_d;
  logic                  running_d;
  logic                  out_d;
  logic                  reset_out_q;
  logic                  reset_asserted_q;
  logic                  timeout_running_q;
  srg_pkg::srg_state_t   state_q;
  srg_pkg::srg_state_t   state_d;

  // pins enter through two flops; idle levels keep reset asserted
  assign pin_raw[`SRG_PIN_SUPPLY] = supply_good;
  assign pin_raw[`SRG_PIN_MANUAL] = manual_reset_request_b;
  assign pin_raw[`SRG_PIN_SELECT] = timeout_select;

  srg_sync #(
    .WIDTH (`SRG_PIN_W),
    .IDLE  (`SRG_PIN_IDLE)
  ) u_pin_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .pin_in   (pin_raw),
    .pin_sync (pin_sync)
  );

  assign supply_good_s = pin_sync[`SRG_PIN_SUPPLY];
  assign manual_b_s    = pin_sync[`SRG_PIN_MANUAL];
  assign select_s      = pin_sync[`SRG_PIN_SELECT];

  // assertion conditions
  assign supply_fault  = ~supply_good_s; // RULE1
  // a floating request has no level in logic; the pad pull-up lands as high
  assign manual_active = HAS_MANUAL &&
                         (manual_b_s == `SRG_LVL_LOW); // RULE3 RULE7
  // without the manual input only the supply counts
  assign cond_active   = supply_fault | manual_active; // RULE6

  // timeout choice; parts without the pin use a fixed option
  assign select_long = HAS_SELECT ? (select_s == `SRG_LVL_HIGH)
                                  : FIXED_SELECT;
  assign sel_last    = select_long ? LONG_LAST : SHORT_LAST; // RULE4

  // the option is frozen while timing so a select glitch cannot cut it short
  assign last_d = (state_q == srg_pkg::srg_st_timing) ? last_q : sel_last;

  assign cnt_done = (cnt_q == last_q);

  // sequencer: hold while any condition is active, then time out
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      srg_pkg::srg_st_hold: begin
        cnt_d = CNT_START; // RULE8
        if (!cond_active) begin
          state_d = srg_pkg::srg_st_timing; // RULE2
        end
      end
      srg_pkg::srg_st_timing: begin
        if (cond_active) begin
          state_d = srg_pkg::srg_st_hold; // RULE8
          cnt_d   = CNT_START;
        end else if (cnt_done) begin
          state_d = srg_pkg::srg_st_run; // RULE2 RULE3
          cnt_d   = CNT_START;
        end else begin
          cnt_d = cnt_q + CNT_STEP;
        end
      end
      srg_pkg::srg_st_run: begin
        cnt_d = CNT_START;
        if (cond_active) begin
          state_d = srg_pkg::srg_st_hold; // RULE1 RULE3
        end
      end
      default: begin
        state_d = srg_pkg::srg_st_hold;
        cnt_d   = CNT_START;
      end
    endcase
  end

  // output levels follow the next state so no output lags a cycle
  assign asserted_d = (state_d != srg_pkg::srg_st_run);
  assign running_d  = (state_d == srg_pkg::srg_st_timing);
  assign out_d      = asserted_d ? OUT_ON : OUT_OFF; // RULE5

  // sequencer state; out of reset the system is held in reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= srg_pkg::srg_st_hold; // RULE8
    end else begin
      state_q <= state_d;
    end
  end

  // timeout counter, cleared whenever a condition is seen
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_q <= CNT_START;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // latched option; reloaded in hold, so its reset value never shortens a hold
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      last_q <= LONG_LAST;
    end else begin
      last_q <= last_d;
    end
  end

  // reset pin, asserted level out of reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reset_out_q <= OUT_ON; // RULE8
    end else begin
      reset_out_q <= out_d;
    end
  end

  // polarity free status of the reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reset_asserted_q <= `SRG_LVL_HIGH;
    end else begin
      reset_asserted_q <= asserted_d;
    end
  end

  // timing status; idle until the first timeout starts
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timeout_running_q <= `SRG_LVL_LOW;
    end else begin
      timeout_running_q <= running_d;
    end
  end

  assign reset_out       = reset_out_q;
  assign reset_asserted  = reset_asserted_q;
  assign timeout_running = timeout_running_q;

endmodule

/* File: srg_regs.svh */
// constants of the supervisor reset generator: clock, timeouts, idle levels
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH

// clock rate of the internal timebase
`define SRG_CLK_FREQ_HZ      125000000
`define SRG_MS_PER_S         1000
`define SRG_CYCLES_PER_MS    (`SRG_CLK_FREQ_HZ / `SRG_MS_PER_S)

// timeout options in milliseconds; plain defaults, the variant sets them
`define SRG_SHORT_TIMEOUT_MS 20
`define SRG_LONG_TIMEOUT_MS  140

// timeout counter width
`define SRG_CNT_W            32

// synchroniser width and idle levels, bit order {select, manual, supply}
`define SRG_PIN_W            3
`define SRG_PIN_SUPPLY       0
`define SRG_PIN_MANUAL       1
`define SRG_PIN_SELECT       2
`define SRG_PIN_IDLE         3'h2

// polarity of the reset output and of the select pin
`define SRG_LVL_HIGH         1'h1
`define SRG_LVL_LOW          1'h0

// first count of a timeout and the step of the counter
`define SRG_CNT_START        0
`define SRG_CNT_STEP         1

`endif

/* File: srg_pkg.sv */
// types of the supervisor reset generator
package srg_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    srg_st_hold   = 2'h0,
    srg_st_timing = 2'h1,
    srg_st_run    = 2'h2
  } srg_state_t;

endpackage

/* File: srg_sync.sv */
// two flip-flop synchroniser for asynchronous pin levels
module srg_sync #(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   IDLE  = '0
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // pin levels and synchronised levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // a zero-width synchroniser has nothing to carry
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("synchroniser width must be at least one");
    end
  endgenerate

  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

/* File: srg_dummy_end.sv */
// holds no logic; every module of the block lives in its own file

/* File: srg_reset_generator_chk.sv */
// assertion checker of the supervisor reset generator
module srg_chk #(
  parameter bit ACTIVE_HIGH          = 1'b0,
  parameter bit HAS_MANUAL           = 1'b1,
  parameter int SHORT_TIMEOUT_CYCLES = 3,
  parameter int LONG_TIMEOUT_CYCLES  = 7
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pins and outputs
  input wire logic supply_good,
  input wire logic manual_reset_request_b,
  input wire logic reset_out,
  input wire logic reset_asserted,
  input wire logic timeout_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // manual pin counts only where the variant has it
  wire logic cond_ok = supply_good && (manual_reset_request_b || !HAS_MANUAL);
  int        run_q;
  // timing cycles, so that a finished hold can be measured
  always_ff @(posedge clock)
    run_q <= (rst_b && timeout_running) ? run_q + 1 : 0;
  property p_low; !supply_good |-> ##3 reset_asserted; endproperty
  a_low: assert property (p_low) else $error("supply reset missed");
  property p_man;
    HAS_MANUAL && !manual_reset_request_b |-> ##3 reset_asserted;
  endproperty
  a_man: assert property (p_man) else $error("manual reset missed");
  property p_pol; reset_out == (reset_asserted ^ !ACTIVE_HIGH); endproperty
  a_pol: assert property (p_pol) else $error("output polarity");
  property p_len; $fell(reset_asserted) |->
    run_q == SHORT_TIMEOUT_CYCLES || run_q == LONG_TIMEOUT_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("hold length");
  property p_hold; timeout_running |-> reset_asserted; endproperty
  a_hold: assert property (p_hold) else $error("released early");
  property p_rst; !cond_ok |-> ##3 !timeout_running; endproperty
  a_rst: assert property (p_rst) else $error("timing not restarted");
  property p_go; $rose(timeout_running) |-> $past(cond_ok, 3); endproperty
  a_go: assert property (p_go) else $error("timing without cause");
  property p_cause; $rose(reset_asserted) |-> !$past(cond_ok, 3); endproperty
  a_cause: assert property (p_cause) else $error("uncaused reset");
  c_fall: cover property ($fell(reset_asserted));
  c_restart: cover property (timeout_running ##1
                             !timeout_running && reset_asserted);
  c_man: cover property (!manual_reset_request_b);
endmodule

bind srg_reset_generator srg_chk #(
  .ACTIVE_HIGH(ACTIVE_HIGH),
  .HAS_MANUAL(HAS_MANUAL),
  .SHORT_TIMEOUT_CYCLES(SHORT_TIMEOUT_CYCLES),
  .LONG_TIMEOUT_CYCLES(LONG_TIMEOUT_CYCLES)
) u_chk (
  .clock(clock),
  .rst_b(rst_b),
  .supply_good(supply_good),
  .manual_reset_request_b(manual_reset_request_b),
  .reset_out(reset_out),
  .reset_asserted(reset_asserted),
  .timeout_running(timeout_running)
);

/* File: srg_sys_model.sv */
// system side model: sees only the reset pin level
module srg_sys_model #(
  parameter bit ACTIVE_HIGH = 1'b0
) (
  // reset from the generator
  input wire logic reset_out,
  // decoded state of the system
  output logic     in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // the system knows its own polarity, nothing else of the generator
  assign in_reset = ACTIVE_HIGH ? reset_out : !reset_out;
endmodule

/* File: srg_reset_generator_tb_top.sv */
// testbench of the supervisor reset generator
module srg_reset_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT = 3;
  localparam int LONG  = 7;
  logic clock                  = 1'b0;
  logic rst_b                  = 1'b0;
  logic supply_good            = 1'b0;
  logic manual_reset_request_b = 1'b1; // pulled up when unused
  logic timeout_select         = 1'b0;
  logic reset_out, reset_asserted, timeout_running, ah_out, in_reset;
  int   miscompares            = 0;
  int   tests_run              = 0;
  int   n;
  // 125 MHz clock
  always #4 clock = ~clock;
  srg_reset_generator #(.SHORT_TIMEOUT_CYCLES(SHORT),
    .LONG_TIMEOUT_CYCLES(LONG)) uut (.clock(clock), .rst_b(rst_b),
    .supply_good(supply_good),
    .manual_reset_request_b(manual_reset_request_b),
    .timeout_select(timeout_select), .reset_out(reset_out),
    .reset_asserted(reset_asserted), .timeout_running(timeout_running));
  // active-high variant without manual or select pin, fixed long option
  srg_reset_generator #(.ACTIVE_HIGH(1'b1), .HAS_MANUAL(1'b0),
    .HAS_SELECT(1'b0), .FIXED_SELECT(1'b1),
    .SHORT_TIMEOUT_CYCLES(SHORT), .LONG_TIMEOUT_CYCLES(LONG)) uut_ah (
    .clock(clock), .rst_b(rst_b), .supply_good(supply_good),
    .manual_reset_request_b(manual_reset_request_b),
    .timeout_select(timeout_select), .reset_out(ah_out),
    .reset_asserted(), .timeout_running());
  srg_sys_model u_sys (.reset_out(reset_out), .in_reset(in_reset));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic pins(input logic s, input logic m, input logic t);
    @(posedge clock);
    supply_good <= s;
    manual_reset_request_b <= m;
    timeout_select <= t;
  endtask
  // clear all causes, count edges until the system leaves reset
  task automatic release_time(input logic t);
    pins(1'b1, 1'b1, t);
    n = 0;
    while (in_reset !== 1'b0 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  task automatic t_power();
    check(reset_out, 1'b0);
    check(ah_out, 1'b1);
    release_time(1'b0);
    check(n, SHORT + 3);
    check(ah_out, 1'b1);
  endtask
  task automatic t_long();
    pins(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clock);
    #1;
    check(reset_asserted, 1'b1);
    check(ah_out, 1'b1);
    release_time(1'b1);
    check(n, LONG + 3);
    check(ah_out, 1'b0);
  endtask
  task automatic t_manual();
    pins(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clock);
    #1;
    check(reset_out, 1'b0);
    check(ah_out, 1'b0);
    release_time(1'b0);
    check(n, SHORT + 3);
  endtask
  // a short drop in mid-timing must bring back the full hold
  task automatic t_restart();
    pins(1'b0, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge clock);
    #1;
    check(timeout_running, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    release_time(1'b1);
    check(n, LONG + 3);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    t_power();
    t_long();
    t_manual();
    t_restart();
    final_report();
  end
  // watchdog well beyond the roughly 60 cycles the tests need
  initial begin
    repeat (1000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule
